/* ahtc_top.sv */
// angle hysteresis filter and turns counter
// assumes sample strobes and register write strobes are synchronous to ref_clk
`timescale 1ns/1ps
module ahtc_top (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // compensated angle stream
   input wire logic angle_valid,
   input wire logic [13:0] comp_angle,
   // low-power turn path steps, one-cycle pulses
   input wire logic turn_step_up,
   input wire logic turn_step_down,
   // register write port
   input wire logic reg_wr,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   // nonvolatile window width and step select
   input wire logic [5:0] angle_window_width,
   input wire logic turn_step_select,
   // outputs
   output logic [13:0] out_angle,
   output logic [11:0] filtered_angle_readback,
   output logic rotation_head_flag,
   output logic filtered_angle_route_enable,
   output logic signed [11:0] turn_count,
   output logic turn_warning
);
   logic [13:0] held;
   logic head_dec;
   logic started;
   logic [15:0] out_cfg;
   ahtc_pkg::ahtc_track_e track;

   // signed modulo distance from held output to new angle
   wire logic [13:0] diff = comp_angle - held;
   wire logic signed [13:0] sdiff = $signed(diff);
   wire logic [13:0] win = {8'h00, angle_window_width};
   wire logic signed [14:0] swin = $signed({1'b0, win});
   wire logic signed [14:0] sd = {sdiff[13], sdiff};
   // motion along head direction, or past the window in the other one
   wire logic fwd = head_dec ? (sd < 0) : (sd > 0);
   wire logic back_out = head_dec ? (sd > swin) : (sd < -swin);
   wire logic zero_win = (angle_window_width == 6'h00);
   wire logic take = !started || zero_win || fwd || back_out;
   // a zero window still tracks direction, any move lands outside it
   wire logic next_head = back_out && started ? !head_dec : head_dec;
   wire logic [13:0] next_held = take ? comp_angle : held;
   // angle, readback and head flag outputs only move on a valid sample; idle cycles carry stale bus data
   wire logic smp = clk_en && angle_valid;

   // hysteresis tracker; start-up places window behind the first angle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         held <= 14'h0000;
         head_dec <= 1'b0;
         started <= 1'b0;
         track <= ahtc_pkg::AHTC_FWD;
      end else if (clk_en && angle_valid) begin
         held <= next_held;
         head_dec <= next_head;
         started <= 1'b1;
         track <= take ? ahtc_pkg::AHTC_FWD : ahtc_pkg::AHTC_HOLD;
      end
   end

   // register writes; output config word and command
   wire logic cfg_wr = reg_wr && (reg_addr == ahtc_pkg::OUT_CFG_OFS);
   wire logic cmd_wr = reg_wr && (reg_addr == ahtc_pkg::CMD_OFS);
   wire logic turn_clr = cmd_wr &&
      (reg_wdata[ahtc_pkg::CMD_SPECIAL_LSB +: 4] == ahtc_pkg::CMD_TURN_RESET);
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         out_cfg <= ahtc_pkg::OUT_CFG_RST;
      end else if (clk_en && cfg_wr) begin
         out_cfg <= reg_wdata;
      end
   end

   // saturation limits by step size
   wire logic signed [11:0] lim_pos = turn_step_select ? ahtc_pkg::LIM45_POS
      : ahtc_pkg::LIM180_POS;
   wire logic signed [11:0] lim_neg = turn_step_select ? ahtc_pkg::LIM45_NEG
      : ahtc_pkg::LIM180_NEG;
   wire logic up = turn_step_up && !turn_step_down;
   wire logic dn = turn_step_down && !turn_step_up;
   wire logic at_pos = turn_count >= lim_pos;
   wire logic at_neg = turn_count <= lim_neg;
   wire logic sat = (up && at_pos) || (dn && at_neg);
   wire logic signed [11:0] next_turn = turn_clr ? 12'sh000 : up && !at_pos ? turn_count + 12'sd1
      : dn && !at_neg ? turn_count - 12'sd1 : turn_count;

   // turns count and sticky warning; a clear is followed by fresh counting
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         turn_count <= 12'sh000;
         turn_warning <= 1'b0;
      end else if (clk_en) begin
         turn_count <= next_turn;
         turn_warning <= turn_clr ? 1'b0 : (turn_warning | sat);
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         out_angle <= 14'h0000;
         filtered_angle_readback <= 12'h000;
         rotation_head_flag <= 1'b0;
      end else if (smp) begin
         out_angle <= out_cfg[ahtc_pkg::ROUTE_EN_BIT] ? next_held : comp_angle;
         filtered_angle_readback <= next_held[13:2];
         rotation_head_flag <= next_head;
      end
   end

   // route flag mirrors the config bit; a route change shows at the next enabled cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         filtered_angle_route_enable <= 1'b0;
      end else if (clk_en) begin
         filtered_angle_route_enable <= out_cfg[ahtc_pkg::ROUTE_EN_BIT];
      end
   end

   a_route_sel: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp && !out_cfg[ahtc_pkg::ROUTE_EN_BIT] |=> out_angle == $past(comp_angle))
      else $error("raw angle not routed");
   a_turn_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && turn_clr |=> turn_count == 0 && !turn_warning)
      else $error("turn clear failed");
   a_turn_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && sat && !turn_clr |=> turn_warning)
      else $error("warning not set");
   a_turn_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      turn_count <= ahtc_pkg::LIM45_POS && turn_count >= ahtc_pkg::LIM45_NEG)
      else $error("turn count out of range");
   a_zero_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && angle_valid && zero_win |=> held == $past(comp_angle))
      else $error("zero window not transparent");
   a_hold_rev: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && angle_valid && started && !zero_win && !fwd && !back_out |=> $stable(held))
      else $error("output moved inside window");
   a_head_flip: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && angle_valid && started && !zero_win && back_out |=> head_dec != $past(head_dec))
      else $error("head not flipped");
   a_dir_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> rotation_head_flag == head_dec)
      else $error("direction flag mismatch");

   // filtered angle routed when enabled
   a_route_filt: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp && out_cfg[ahtc_pkg::ROUTE_EN_BIT] |=> out_angle == $past(next_held))
      else $error("filtered angle not routed");

   // readback is the filtered angle at reduced resolution
   a_readback_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp |=> filtered_angle_readback == $past(next_held[13:2]))
      else $error("readback bits wrong");

   // forward motion passes straight through
   a_fwd_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp && started && fwd |=> held == $past(comp_angle))
      else $error("forward angle not followed");

   // first sample adopted with increasing head
   a_first_adopt: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp && !started |=> held == $past(comp_angle) && !head_dec)
      else $error("first angle not adopted");

   // low enable freezes the filter
   a_freeze_angle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !clk_en |=> $stable(held) && $stable(out_angle) && $stable(head_dec))
      else $error("filter moved while frozen");

   // low enable freezes the counter
   a_freeze_turns: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !clk_en |=> $stable(turn_count) && $stable(turn_warning))
      else $error("counter moved while frozen");

   // no sample, no filter movement
   a_no_sample: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !angle_valid |=> $stable(held) && $stable(head_dec))
      else $error("filter moved without sample");

   // idle cycles keep the routed angle
   a_raw_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !angle_valid |=> $stable(out_angle))
      else $error("output angle moved without sample");

   // idle cycles keep the readback
   a_readback_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !angle_valid |=> $stable(filtered_angle_readback))
      else $error("readback moved without sample");

   // idle cycles keep the direction flag
   a_flag_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !angle_valid |=> $stable(rotation_head_flag))
      else $error("direction flag moved without sample");

   // head only flips on an exit behind it
   a_head_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp && !back_out |=> head_dec == $past(head_dec))
      else $error("head flipped without exit");

   // tracker state follows the take decision
   a_track_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
      smp |=> (track == ahtc_pkg::AHTC_HOLD) == !$past(take))
      else $error("tracker state wrong");

   // reset state of filter and counter
   a_reset_state: assert property (@(posedge ref_clk)
      sys_rst |=> !started && !head_dec && turn_count == 12'sh000 && !turn_warning)
      else $error("reset state wrong");

   // single up step counts one
   a_count_up: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && up && !at_pos && !turn_clr |=> turn_count == $past(turn_count) + 12'sd1)
      else $error("up step not counted");

   // single down step counts one
   a_count_down: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && dn && !at_neg && !turn_clr |=> turn_count == $past(turn_count) - 12'sd1)
      else $error("down step not counted");

   // positive limit holds in 45-degree mode
   a_lim_pos45: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && turn_step_select && up && turn_count == ahtc_pkg::LIM45_POS && !turn_clr
      |=> turn_count == ahtc_pkg::LIM45_POS)
      else $error("45 positive limit wrapped");

   // negative limit holds in 45-degree mode
   a_lim_neg45: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && turn_step_select && dn && turn_count == ahtc_pkg::LIM45_NEG && !turn_clr
      |=> turn_count == ahtc_pkg::LIM45_NEG)
      else $error("45 negative limit wrapped");

   // positive limit holds in 180-degree mode
   a_lim_pos180: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !turn_step_select && up && turn_count == ahtc_pkg::LIM180_POS && !turn_clr
      |=> turn_count == ahtc_pkg::LIM180_POS)
      else $error("180 positive limit wrapped");

   // negative limit holds in 180-degree mode
   a_lim_neg180: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !turn_step_select && dn && turn_count == ahtc_pkg::LIM180_NEG && !turn_clr
      |=> turn_count == ahtc_pkg::LIM180_NEG)
      else $error("180 negative limit wrapped");

   // warning stays until cleared
   a_warn_stays: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && turn_warning && !turn_clr |=> turn_warning)
      else $error("warning dropped");

   // warning only raised by saturation
   a_warn_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !turn_warning && !sat |=> !turn_warning)
      else $error("warning without saturation");

   // clear wins over a saturating step
   a_clear_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && turn_clr && sat |=> !turn_warning)
      else $error("clear lost to saturation");

   // idle turn path keeps the count
   a_count_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !turn_step_up && !turn_step_down && !turn_clr |=> $stable(turn_count))
      else $error("count moved without step");

   // both step pulses together are ignored
   a_both_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && turn_step_up && turn_step_down && !turn_clr |=> $stable(turn_count))
      else $error("conflicting steps counted");

   // config word takes the written data
   a_cfg_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && cfg_wr |=> out_cfg == $past(reg_wdata))
      else $error("config write lost");

   // config word untouched by other cycles
   a_cfg_other: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !cfg_wr |=> $stable(out_cfg))
      else $error("config changed without write");

   // route flag mirrors the config bit
   a_route_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> filtered_angle_route_enable == $past(out_cfg[ahtc_pkg::ROUTE_EN_BIT]))
      else $error("route flag mismatch");
endmodule

/* ahtc_pkg.sv */
// constants shared by the angle hysteresis and turns counter block
// assumes a 14-bit compensated angle and a signed turns count from the low-power path
package ahtc_pkg;
   localparam int ANGLE_W = 14;
   localparam int WIN_W = 6;
   localparam int READBACK_W = 12;
   localparam int TURN_W = 12;
   // register offsets
   localparam logic [5:0] OUT_CFG_OFS = 6'h19;
   localparam logic [5:0] CMD_OFS = 6'h1e;
   localparam logic [5:0] WARN_OFS = 6'h26;
   // field positions
   localparam int ROUTE_EN_BIT = 12;
   localparam int WARN_TURN_BIT = 0;
   localparam int CMD_SPECIAL_LSB = 12;
   localparam logic [3:0] CMD_TURN_RESET = 4'h1;
   // reset values
   localparam logic [15:0] OUT_CFG_RST = 16'h0000;
   // saturation limits, 45 and 180 degree modes
   localparam logic signed [TURN_W-1:0] LIM45_POS = 12'sd2047;
   localparam logic signed [TURN_W-1:0] LIM45_NEG = -12'sd2048;
   localparam logic signed [TURN_W-1:0] LIM180_POS = 12'sd511;
   localparam logic signed [TURN_W-1:0] LIM180_NEG = -12'sd512;
   typedef enum logic [1:0] {AHTC_FWD = 2'b00, AHTC_HOLD = 2'b01} ahtc_track_e;
endpackage

/* ahtc_far_model.sv */
// far-side model: angle signal path and low-power turn path
// assumes the bench calls its tasks; it drives on falling ref_clk edges
`timescale 1ns/1ps
module ahtc_far_model (
   // clock
   input wire logic ref_clk,
   // angle stream and turn steps
   output logic angle_valid,
   output logic [13:0] comp_angle,
   output logic turn_step_up,
   output logic turn_step_down
);
   initial begin
      angle_valid = 1'b0;
      comp_angle = 14'h0000;
      turn_step_up = 1'b0;
      turn_step_down = 1'b0;
   end
   // one sample; data inverted after the strobe so stale values never match
   task automatic send_angle(input logic [13:0] a);
      @(negedge ref_clk);
      angle_valid = 1'b1;
      comp_angle = a;
      @(negedge ref_clk);
      angle_valid = 1'b0;
      comp_angle = ~a;
   endtask
   // n back-to-back step pulses, uncompensated path
   task automatic steps(input logic up, input int n);
      @(negedge ref_clk);
      turn_step_up = up;
      turn_step_down = !up;
      repeat (n) @(negedge ref_clk);
      turn_step_up = 1'b0;
      turn_step_down = 1'b0;
   endtask
endmodule

/* tb_angle_hysteresis_turns_counter.sv */
// bench for the angle hysteresis filter and turns counter
// assumes outputs settle within two cycles of a taken request
`timescale 1ns/1ps
module tb_angle_hysteresis_turns_counter;
   logic ref_clk = 1'b0;
   logic sys_rst, clk_en, reg_wr, turn_step_select, angle_valid, turn_step_up, turn_step_down;
   logic [5:0] reg_addr, angle_window_width;
   logic [15:0] reg_wdata;
   logic [13:0] comp_angle, out_angle;
   logic [11:0] filtered_angle_readback;
   logic signed [11:0] turn_count;
   logic rotation_head_flag, filtered_angle_route_enable, turn_warning;
   int miscompares = 0;
   int samples_checked = 0;
   always #20 ref_clk = ~ref_clk;
   ahtc_far_model f (.ref_clk(ref_clk), .angle_valid(angle_valid), .comp_angle(comp_angle),
      .turn_step_up(turn_step_up), .turn_step_down(turn_step_down));
   ahtc_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .angle_valid(angle_valid), .comp_angle(comp_angle), .turn_step_up(turn_step_up),
      .turn_step_down(turn_step_down), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .angle_window_width(angle_window_width),
      .turn_step_select(turn_step_select), .out_angle(out_angle),
      .filtered_angle_readback(filtered_angle_readback),
      .rotation_head_flag(rotation_head_flag),
      .filtered_angle_route_enable(filtered_angle_route_enable),
      .turn_count(turn_count), .turn_warning(turn_warning));
   task automatic settle();
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      settle();
   endtask
   task automatic ang(input logic [13:0] a, input logic [13:0] e, input logic h);
      f.send_angle(a);
      settle();
      chk("out_angle", e, out_angle);
      chk("head_flag", {13'h0000, h}, {13'h0000, rotation_head_flag});
   endtask
   task automatic turns(input logic [13:0] e, input logic w);
      settle();
      chk("turn_count", e, {2'b00, turn_count});
      chk("turn_warning", {13'h0000, w}, {13'h0000, turn_warning});
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog so a stuck run still reports
   initial begin
      #2000000;
      miscompares++;
      end_of_test();
   end
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
      angle_window_width = 6'h04;
      turn_step_select = 1'b0;
      repeat (6) @(negedge ref_clk);
      sys_rst = 1'b0;
      turns(14'h0000, 1'b0);
      wr(ahtc_pkg::OUT_CFG_OFS, 16'h1000);
      chk("route_en", 14'h0001, {13'h0000, filtered_angle_route_enable});
      ang(14'h0064, 14'h0064, 1'b0);
      chk("readback", 14'h0019, {2'b00, filtered_angle_readback});
      ang(14'h0066, 14'h0066, 1'b0);
      ang(14'h0063, 14'h0066, 1'b0);
      ang(14'h0061, 14'h0061, 1'b1);
      ang(14'h0062, 14'h0061, 1'b1);
      angle_window_width = 6'h00;
      ang(14'h0070, 14'h0070, 1'b0);
      wr(ahtc_pkg::OUT_CFG_OFS, 16'h0000);
      chk("route_en", 14'h0000, {13'h0000, filtered_angle_route_enable});
      ang(14'h0080, 14'h0080, 1'b0);
      clk_en = 1'b0;
      f.send_angle(14'h0100);
      settle();
      chk("frozen_angle", 14'h0080, out_angle);
      clk_en = 1'b1;
      f.steps(1'b1, 515);
      turns(14'h01ff, 1'b1);
      wr(6'h20, 16'h1000);
      turns(14'h01ff, 1'b1);
      wr(ahtc_pkg::CMD_OFS, 16'h1000);
      turns(14'h0000, 1'b0);
      f.steps(1'b0, 514);
      turns(14'h0e00, 1'b1);
      wr(ahtc_pkg::CMD_OFS, 16'h1000);
      turn_step_select = 1'b1;
      f.steps(1'b0, 2050);
      turns(14'h0800, 1'b1);
      wr(ahtc_pkg::CMD_OFS, 16'h1000);
      f.steps(1'b1, 2);
      turns(14'h0002, 1'b0);
      end_of_test();
   end
endmodule
